// >>> shared/klt_consts.vh
// Constants for the key learning and tag detect command block.
`ifndef KLT_CONSTS_VH
`define KLT_CONSTS_VH
// ==================================================================
// Register byte offsets
`define KLT_A_CMD      8'h00
`define KLT_A_ARG0     8'h04
`define KLT_A_ARG1     8'h08
`define KLT_A_ARG2     8'h0C
`define KLT_A_RESP     8'h10
`define KLT_A_RVAL0    8'h14
`define KLT_A_RVAL1    8'h18
`define KLT_A_RVAL2    8'h1C
`define KLT_A_ROLE     8'h20
// ==================================================================
// Command codes and fields
`define KLT_C_LEARN    4'h1
`define KLT_C_BIND     4'h2
`define KLT_C_ONEP     4'h3
`define KLT_C_TAG      4'h4
`define KLT_C_HOLD     4'h5
`define KLT_C_KEYCFG   4'h6
`define KLT_CMD_QUERY  7
`define KLT_RESP_OK    8
`define KLT_RESP_ERR   9
// ==================================================================
// Values
`define KLT_ONEP_ON    8'hF1
`define KLT_ONEP_OFF   8'h00
`define KLT_ADDR_MIN   16'h0001
`define KLT_ADDR_MAX   16'hFF00
`define KLT_TAG_MAX    4'h9
`define KLT_HOLD_MAX   4'h9
`define KLT_HOLD_RST   4'h3
`define KLT_ROLE_CENTRAL 4'h1
`define KLT_ROLE_TAG     4'h8
`define KLT_ROLE_RST     4'h0
// ==================================================================
// Timing
`define KLT_CLK_HZ     10000000
`define KLT_HOLD_UNIT_S 1
`define KLT_SEC_CYC    (`KLT_HOLD_UNIT_S * `KLT_CLK_HZ)
`endif

// >>> verilog/klt_cmd_core.v
// Command interpreter for key learning, one-press binding and tag detection.
`timescale 1ns/1ps
`include "klt_consts.vh"
module klt_cmd_core #(
	parameter SEC_CYC = `KLT_SEC_CYC
) (
	input  wire        clk_sys_i,
	input  wire        resetn_i,
	input  wire [7:0]  addr_i,
	input  wire [31:0] wdata_i,
	input  wire        wr_i,
	input  wire        rd_i,
	output reg  [31:0] rdata_o,
	input  wire        rkey_valid_i,
	input  wire [15:0] rkey_addr_i,
	input  wire [3:0]  rkey_pin_i,
	input  wire        rkey_level_i,
	input  wire        bind_button_pin_i,
	input  wire        scan_valid_i,
	input  wire [47:0] scan_addr_i,
	input  wire [7:0]  scan_rssi_i,
	input  wire        tag_seen_i,
	input  wire [47:0] tag_mac_i,
	output reg  [4:0]  out_o,
	output reg         connect_req_o,
	output reg  [47:0] connect_addr_o
);

	function in_1_5;
		input [3:0] v;
		in_1_5 = (v >= 4'h1) && (v <= 4'h5);
	endfunction

	// The divider is 24 bits wide, which covers a one-second period for clocks up to 16 MHz.
	localparam [31:0] DIV_LAST = SEC_CYC - 1;

	// ==================================================================
	// State
	reg        learn_r;
	reg [7:0]  onep_r;
	reg [3:0]  role_r;
	reg [31:0] arg0_r;
	reg [31:0] arg1_r;
	reg [15:0] arg2_r;
	reg [3:0]  resp_code_r;
	reg        resp_ok_r;
	reg        resp_err_r;
	reg [31:0] rval0_r;
	reg [31:0] rval1_r;
	reg [15:0] rval2_r;
	reg [3:0]  lb_pin_r  [1:5];
	reg [15:0] lb_addr_r [1:5];
	reg [3:0]  kcfg_r    [1:5];
	reg [3:0]  tag_out_r [0:9];
	reg [47:0] tag_mac_r [0:9];
	reg [3:0]  hold_r    [0:9];
	reg [3:0]  tcnt_r    [0:9];
	reg [5:1]  key_lvl_r;
	reg [23:0] div_r;
	reg        tick_r;
	reg        btn_s1_r;
	reg        btn_s2_r;
	reg        btn_d_r;
	reg        best_vld_r;
	reg [7:0]  best_rssi_r;
	reg [47:0] best_addr_r;
	// Each process keeps its own loop index.
	integer    i;
	integer    j;
	integer    k;
	integer    t;

	wire [3:0]  p1 = arg0_r[3:0];
	wire [3:0]  p2 = arg0_r[7:4];
	wire [15:0] p3 = arg0_r[23:8];
	wire [7:0]  pb = arg0_r[7:0];
	wire        cmd_go = wr_i && (addr_i == `KLT_A_CMD);
	wire [3:0]  code = wdata_i[3:0];
	wire        qry = wdata_i[`KLT_CMD_QUERY];
	wire        press = btn_s2_r && !btn_d_r;
	wire        wr_arg0 = wr_i && (addr_i == `KLT_A_ARG0);
	wire        wr_arg1 = wr_i && (addr_i == `KLT_A_ARG1);
	wire        wr_arg2 = wr_i && (addr_i == `KLT_A_ARG2);
	wire        wr_role = wr_i && (addr_i == `KLT_A_ROLE);

	// ==================================================================
	// Argument check
	// A refused command changes no state; only the response registers move.
	reg cmd_ok;
	always @* begin
		case (code)
			`KLT_C_LEARN: cmd_ok = qry || (p1 <= 4'h1);
			`KLT_C_BIND: cmd_ok = in_1_5(p1) && (qry || (learn_r && in_1_5(p2) &&
				(p3 >= `KLT_ADDR_MIN) && (p3 <= `KLT_ADDR_MAX)));
			`KLT_C_ONEP: cmd_ok = qry || (pb == `KLT_ONEP_ON) || (pb == `KLT_ONEP_OFF);
			`KLT_C_TAG: cmd_ok = (p1 <= `KLT_TAG_MAX) && (qry || in_1_5(p2));
			`KLT_C_HOLD: cmd_ok = (p1 <= `KLT_TAG_MAX) && (qry || (p2 <= `KLT_HOLD_MAX));
			`KLT_C_KEYCFG: cmd_ok = in_1_5(p1) && (qry || (p2 <= 4'h5));
			default: cmd_ok = 1'b0;
		endcase
	end

	// ==================================================================
	// Read mux
	// Unused offsets read as zero so that software never picks up stale data.
	reg [31:0] resp_word;
	always @* begin
		resp_word = 32'h00000000;
		resp_word[3:0] = resp_code_r;
		resp_word[`KLT_RESP_OK] = resp_ok_r;
		resp_word[`KLT_RESP_ERR] = resp_err_r;
	end

	reg [31:0] rd_mux;
	always @* begin
		case (addr_i)
			`KLT_A_ARG0: rd_mux = arg0_r;
			`KLT_A_ARG1: rd_mux = arg1_r;
			`KLT_A_ARG2: rd_mux = {16'h0000, arg2_r};
			`KLT_A_RESP: rd_mux = resp_word;
			`KLT_A_RVAL0: rd_mux = rval0_r;
			`KLT_A_RVAL1: rd_mux = rval1_r;
			`KLT_A_RVAL2: rd_mux = {16'h0000, rval2_r};
			`KLT_A_ROLE: rd_mux = {28'h0000000, role_r};
			default: rd_mux = 32'h00000000;
		endcase
	end

	// Tag outputs: any live counter raises the output its entry names.
	reg [5:1] tag_lvl;
	always @* begin
		tag_lvl = 5'h00;
		for (i = 0; i < 10; i = i + 1) begin
			if ((tcnt_r[i] != 4'h0) && in_1_5(tag_out_r[i])) begin
				tag_lvl[tag_out_r[i]] = 1'b1;
			end
		end
	end

	// ==================================================================
	// Registers and command execution
	always @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			learn_r <= 1'b0;
			onep_r <= `KLT_ONEP_OFF;
			role_r <= `KLT_ROLE_RST;
			arg0_r <= 32'h00000000;
			arg1_r <= 32'h00000000;
			arg2_r <= 16'h0000;
			resp_code_r <= 4'h0;
			resp_ok_r <= 1'b0;
			resp_err_r <= 1'b0;
			rval0_r <= 32'h00000000;
			rval1_r <= 32'h00000000;
			rval2_r <= 16'h0000;
			rdata_o <= 32'h00000000;
			for (j = 1; j <= 5; j = j + 1) begin
				lb_pin_r[j] <= 4'h0;
				lb_addr_r[j] <= 16'h0000;
				kcfg_r[j] <= 4'h0;
			end
			for (j = 0; j < 10; j = j + 1) begin
				tag_out_r[j] <= 4'h0;
				tag_mac_r[j] <= 48'h000000000000;
				hold_r[j] <= `KLT_HOLD_RST;
			end
		end else begin
			rdata_o <= rd_i ? rd_mux : 32'h00000000;
			if (wr_arg0) begin
				arg0_r <= wdata_i;
			end
			if (wr_arg1) begin
				arg1_r <= wdata_i;
			end
			if (wr_arg2) begin
				arg2_r <= wdata_i[15:0];
			end
			if (wr_role) begin
				role_r <= wdata_i[3:0];
			end
			// The command word acts on the arguments already held, so they are written first.
			if (cmd_go) begin
				resp_code_r <= code;
				resp_ok_r <= cmd_ok;
				resp_err_r <= !cmd_ok;
				rval0_r <= 32'h00000000;
				rval1_r <= 32'h00000000;
				rval2_r <= 16'h0000;
				if (cmd_ok) begin
					case (code)
						`KLT_C_LEARN: begin
							if (qry) rval0_r <= {31'h00000000, learn_r};
							else learn_r <= p1[0];
						end
						`KLT_C_BIND: begin
							if (qry) begin
								rval0_r <= {8'h00, lb_addr_r[p1], lb_pin_r[p1], p1};
							end else begin
								lb_pin_r[p1] <= p2;
								lb_addr_r[p1] <= p3;
							end
						end
						`KLT_C_ONEP: begin
							if (qry) rval0_r <= {24'h000000, onep_r};
							else onep_r <= pb;
						end
						`KLT_C_TAG: begin
							if (qry) begin
								rval0_r <= {24'h000000, tag_out_r[p1], p1};
								rval1_r <= tag_mac_r[p1][31:0];
								rval2_r <= tag_mac_r[p1][47:32];
							end else begin
								tag_out_r[p1] <= p2;
								tag_mac_r[p1] <= {arg2_r, arg1_r};
							end
						end
						`KLT_C_HOLD: begin
							if (qry) rval0_r <= {24'h000000, hold_r[p1], p1};
							else hold_r[p1] <= p2;
						end
						`KLT_C_KEYCFG: begin
							if (qry) rval0_r <= {24'h000000, kcfg_r[p1], p1};
							else kcfg_r[p1] <= p2;
						end
						default: begin
						end
					endcase
				end
			end
		end
	end

	// ==================================================================
	// Remote key to output levels
	always @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			key_lvl_r <= 5'h00;
		end else if (rkey_valid_i) begin
			if (learn_r) begin
				// Every matching entry follows, so one key can drive several outputs.
				// Address 0000 marks an unbound entry, which must never follow a key event.
				for (k = 1; k <= 5; k = k + 1) begin
					if ((lb_addr_r[k] == rkey_addr_i) && (lb_pin_r[k] == rkey_pin_i) &&
						(lb_addr_r[k] != 16'h0000)) begin
						key_lvl_r[k] <= rkey_level_i;
					end
				end
			end else if (in_1_5(rkey_pin_i) && in_1_5(kcfg_r[rkey_pin_i])) begin
				key_lvl_r[kcfg_r[rkey_pin_i]] <= rkey_level_i;
			end
		end
	end

	// ==================================================================
	// Seconds tick and tag hold counters
	always @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			div_r <= 24'h000000;
			tick_r <= 1'b0;
			for (t = 0; t < 10; t = t + 1) begin
				tcnt_r[t] <= 4'h0;
			end
		end else begin
			tick_r <= (div_r == DIV_LAST[23:0]);
			div_r <= (div_r == DIV_LAST[23:0]) ? 24'h000000 : div_r + 24'h000001;
			for (t = 0; t < 10; t = t + 1) begin
				// The extra second covers the tick phase, so expiry is never early.
				// A sighting wins over a tick in the same cycle, so a tag in range never drops.
				if (tag_seen_i && (tag_mac_r[t] == tag_mac_i) && in_1_5(tag_out_r[t])) begin
					tcnt_r[t] <= hold_r[t] + 4'h1;
				end else if (tick_r && (tcnt_r[t] != 4'h0)) begin
					tcnt_r[t] <= tcnt_r[t] - 4'h1;
				end
			end
		end
	end

	// ==================================================================
	// Bind button synchroniser and edge detector
	// The pin is asynchronous, so only the second stage feeds any logic.
	always @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			btn_s1_r <= 1'b0;
			btn_s2_r <= 1'b0;
			btn_d_r <= 1'b0;
		end else begin
			btn_s1_r <= bind_button_pin_i;
			btn_s2_r <= btn_s1_r;
			btn_d_r <= btn_s2_r;
		end
	end

	// ==================================================================
	// One-press binding to the strongest peer
	// A scan in the same cycle as a bind is dropped; the next scan rebuilds the record.
	always @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			best_vld_r <= 1'b0;
			best_rssi_r <= 8'h00;
			best_addr_r <= 48'h000000000000;
			connect_req_o <= 1'b0;
			connect_addr_o <= 48'h000000000000;
		end else begin
			connect_req_o <= 1'b0;
			if (press && (role_r == `KLT_ROLE_CENTRAL) && (onep_r == `KLT_ONEP_ON) &&
				best_vld_r) begin
				connect_req_o <= 1'b1;
				connect_addr_o <= best_addr_r;
				best_vld_r <= 1'b0;
			end else if (scan_valid_i && (!best_vld_r || (scan_rssi_i > best_rssi_r))) begin
				best_vld_r <= 1'b1;
				best_rssi_r <= scan_rssi_i;
				best_addr_r <= scan_addr_i;
			end
		end
	end

	// ==================================================================
	// Output pins
	// The role selects the source, so a role write moves the pins on the next edge.
	always @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			out_o <= 5'h00;
		end else begin
			out_o <= (role_r == `KLT_ROLE_TAG) ? tag_lvl : key_lvl_r;
		end
	end

endmodule // klt_cmd_core

// >>> bench/klt_checker.sv
// Port timing checker of the command block.
`timescale 1ns/1ps
module klt_checker #(parameter SEC_CYC = 20) (
	input wire        clk_sys_i,
	input wire        resetn_i,
	input wire [7:0]  addr_i,
	input wire [31:0] wdata_i,
	input wire        wr_i,
	input wire        rd_i,
	input wire [31:0] rdata_o,
	input wire        rkey_valid_i,
	input wire        bind_button_pin_i,
	input wire        tag_seen_i,
	input wire [4:0]  out_o,
	input wire        connect_req_o,
	input wire [47:0] connect_addr_o
);
	// ====
	// Properties
	localparam int LIM = 10 * SEC_CYC + 4;
	reg [31:0] hc_r;
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!resetn_i);
	// Key outputs never stay up long here, so a long unattended high means a stuck hold.
	always @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i)
			hc_r <= 32'h0;
		else if (rkey_valid_i || tag_seen_i || out_o == 5'h0)
			hc_r <= 32'h0;
		else
			hc_r <= hc_r + 32'h1;
	end
	rdata_idle_a: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
		else $error("read data outside slot");
	unmapped_read_a: assert property (rd_i && addr_i > 8'h20 |=> rdata_o == 32'h0)
		else $error("unmapped read not zero");
	bad_code_a: assert property (wr_i && addr_i == 8'h00 && wdata_i[3:0] == 4'hF
		##1 rd_i && addr_i == 8'h10 |=> rdata_o[9:8] == 2'b10) else $error("bad code taken");
	req_pulse_a: assert property (connect_req_o |=> !connect_req_o)
		else $error("connect request too long");
	req_cause_a: assert property (connect_req_o |-> $past(bind_button_pin_i, 3))
		else $error("connect without press");
	addr_hold_a: assert property ($changed(connect_addr_o) |-> connect_req_o)
		else $error("peer address moved");
	out_rise_a: assert property ((out_o & ~$past(out_o)) != 5'h0
		|-> $past(rkey_valid_i, 2) || $past(tag_seen_i, 2)) else $error("output rose alone");
	hold_limit_a: assert property (hc_r <= LIM)
		else $error("output held too long");
endmodule // klt_checker
bind klt_cmd_core klt_checker #(.SEC_CYC(SEC_CYC)) i_chk (.clk_sys_i, .resetn_i, .addr_i,
	.wdata_i, .wr_i, .rd_i, .rdata_o, .rkey_valid_i, .bind_button_pin_i, .tag_seen_i, .out_o,
	.connect_req_o, .connect_addr_o);

// >>> bench/klt_host_model.sv
// Register port master standing in for the host controller.
`timescale 1ns/1ps
module klt_host_model (
	input  wire        clk_sys_i,
	output reg  [7:0]  addr_o = 8'h00,
	output reg  [31:0] wdata_o = 32'h0,
	output reg         wr_o = 1'b0,
	output reg         rd_o = 1'b0
);
	// ====
	// Bus cycles
	// Idle data flips on each non-write call of cyc so a stale write value never looks valid.
	task cyc(input w, input r, input [7:0] a, input [31:0] d);
		@(posedge clk_sys_i);
		wr_o <= w;
		rd_o <= r;
		addr_o <= a;
		wdata_o <= w ? d : ~wdata_o;
	endtask
endmodule // klt_host_model

// >>> bench/key_learn_and_tag_detect_cmds_tb.sv
// Self-checking bench of the key learning and tag detect command block.
`timescale 1ns/1ps
module key_learn_and_tag_detect_cmds_tb;
	reg         clk_sys_i = 1'b0, resetn_i = 1'b0, rkey_valid_i = 1'b0, rkey_level_i = 1'b0;
	reg         bind_button_pin_i = 1'b0, scan_valid_i = 1'b0, tag_seen_i = 1'b0, rd_q = 1'b0;
	reg  [15:0] rkey_addr_i = 16'h0, sa;
	reg  [3:0]  rkey_pin_i = 4'h0;
	reg  [7:0]  scan_rssi_i = 8'h0;
	reg  [47:0] scan_addr_i = 48'h0, tag_mac_i = 48'h0, a1, a2, mac;
	reg  [31:0] seed = 32'h1EC3;
	reg  [63:0] q[$];
	reg  [63:0] e;
	wire [7:0]  addr_i;
	wire [31:0] wdata_i, rdata_o;
	wire        wr_i, rd_i, connect_req_o;
	wire [4:0]  out_o;
	wire [47:0] connect_addr_o;
	int         mismatches = 0, compares = 0, cyc_n = 0, i;
	always #50 clk_sys_i = ~clk_sys_i;
	klt_host_model i_host (.clk_sys_i, .addr_o(addr_i), .wdata_o(wdata_i), .wr_o(wr_i),
		.rd_o(rd_i));
	klt_cmd_core #(.SEC_CYC(20)) i_dut (.clk_sys_i, .resetn_i, .addr_i, .wdata_i, .wr_i, .rd_i,
		.rdata_o, .rkey_valid_i, .rkey_addr_i, .rkey_pin_i, .rkey_level_i, .bind_button_pin_i,
		.scan_valid_i, .scan_addr_i, .scan_rssi_i, .tag_seen_i, .tag_mac_i, .out_o,
		.connect_req_o, .connect_addr_o);
	// ====
	// Helpers
	function logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task cmp(input string nm, input [47:0] exp, input [47:0] act);
		compares++;
		if (act !== exp) begin
			mismatches++;
			$display("BAD %s exp %h got %h", nm, exp, act);
		end
	endtask
	task wr(input [7:0] a, input [31:0] d);
		i_host.cyc(1'b1, 1'b0, a, d);
	endtask
	task rd(input [7:0] a, input [31:0] m, input [31:0] x);
		q.push_back({m, x});
		i_host.cyc(1'b0, 1'b1, a, 32'h0);
	endtask
	// The command word goes last; it closes the command as the line end does.
	task cmd(input [7:0] c, input [31:0] p0, input [31:0] p1, input [31:0] p2);
		wr(8'h04, p0);
		wr(8'h08, p1);
		wr(8'h0C, p2);
		wr(8'h00, {24'h0, c});
	endtask
	task idle(input int n);
		i_host.cyc(1'b0, 1'b0, 8'h00, 32'h0);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask
	task pulse(input [1:0] k, input [47:0] a, input [7:0] r);
		i_host.cyc(1'b0, 1'b0, 8'h00, 32'h0);
		rkey_valid_i <= k == 2'd0;
		scan_valid_i <= k == 2'd1;
		tag_seen_i <= k == 2'd2;
		{rkey_addr_i, rkey_pin_i, rkey_level_i} <= {a[15:0], r[3:0], r[4]};
		{scan_addr_i, scan_rssi_i, tag_mac_i} <= {a, r, a};
		@(posedge clk_sys_i);
		{rkey_valid_i, scan_valid_i, tag_seen_i} <= 3'b000;
		idle(3);
	endtask
	task test_done;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// ====
	// Read watcher and time limit
	always @(posedge clk_sys_i) begin
		if (rd_q) begin
			e = q.pop_front();
			cmp("rdata", e[31:0], rdata_o & e[63:32]);
		end
		rd_q <= rd_i;
	end
	always @(posedge clk_sys_i) begin
		cyc_n++;
		if (cyc_n == 2000) begin
			mismatches++;
			test_done;
		end
	end
	// ====
	// Scenarios
	initial begin
		repeat (12) @(posedge clk_sys_i);
		resetn_i <= 1'b1;
		sa = 16'(rnd() % 32'hFF00) + 16'h1;
		cmd(8'h81, 0, 0, 0);
		rd(8'h14, 32'h0F, 32'h0);
		cmd(8'h83, 0, 0, 0);
		rd(8'h14, 32'hFF, 32'h0);
		cmd(8'h85, 4, 0, 0);
		rd(8'h14, 32'hF0, 32'h30);
		cmd(8'h82, 1, 0, 0);
		rd(8'h14, 32'hFFFFF0, 32'h0);
		cmd(8'h02, {sa, 8'h11}, 0, 0);
		rd(8'h10, 32'h30F, 32'h202);
		wr(8'h00, 32'h0F);
		rd(8'h10, 32'h300, 32'h200);
		rd(8'h44, 32'hFFFFFFFF, 32'h0);
		cmd(8'h01, 1, 0, 0);
		rd(8'h10, 32'h30F, 32'h101);
		cmd(8'h81, 0, 0, 0);
		rd(8'h14, 32'h0F, 32'h1);
		cmd(8'h02, 32'hFF0111, 0, 0);
		rd(8'h10, 32'h300, 32'h200);
		cmd(8'h02, {sa, 8'h11}, 0, 0);
		cmd(8'h02, {sa, 8'h12}, 0, 0);
		cmd(8'h02, {sa, 8'h25}, 0, 0);
		cmd(8'h06, 8'h51, 0, 0);
		rd(8'h10, 32'h30F, 32'h106);
		pulse(2'd0, sa, 8'h11);
		cmp("out", 5'h03, out_o);
		pulse(2'd0, sa, 8'h12);
		cmp("out", 5'h13, out_o);
		pulse(2'd0, sa, 8'h01);
		pulse(2'd0, sa, 8'h02);
		cmp("out", 5'h00, out_o);
		cmd(8'h01, 0, 0, 0);
		cmd(8'h81, 0, 0, 0);
		rd(8'h14, 32'h0F, 32'h0);
		pulse(2'd0, sa, 8'h11);
		cmp("out", 5'h10, out_o);
		pulse(2'd0, sa, 8'h01);
		cmp("out", 5'h00, out_o);
		cmd(8'h03, 8'hF1, 0, 0);
		cmd(8'h83, 0, 0, 0);
		rd(8'h14, 32'hFF, 32'hF1);
		wr(8'h20, 1);
		a1 = {rnd(), 16'(rnd())};
		a2 = {rnd(), 16'(rnd())};
		pulse(2'd1, a2, {1'b1, seed[6:0]});
		pulse(2'd1, a1, 8'h40);
		bind_button_pin_i <= 1'b1;
		for (i = 0; i < 12 && connect_req_o !== 1'b1; i++)
			@(posedge clk_sys_i);
		cmp("req", 1'b1, connect_req_o);
		cmp("bind", a2, connect_addr_o);
		bind_button_pin_i <= 1'b0;
		wr(8'h20, 8);
		mac = {rnd(), 16'(rnd())};
		cmd(8'h04, 8'h21, mac[31:0], mac[47:32]);
		cmd(8'h05, 8'h11, 0, 0);
		cmd(8'h84, 1, 0, 0);
		rd(8'h14, 32'hFF, 32'h21);
		rd(8'h18, 32'hFFFFFFFF, mac[31:0]);
		rd(8'h1C, 32'hFFFF, {16'h0, mac[47:32]});
		cmd(8'h85, 1, 0, 0);
		rd(8'h14, 32'hFF, 32'h11);
		pulse(2'd2, mac, 8'h0);
		cmp("tag", 5'h02, out_o);
		idle(20);
		pulse(2'd2, mac, 8'h0);
		idle(12);
		cmp("tag", 5'h02, out_o);
		idle(40);
		cmp("tag", 5'h00, out_o);
		test_done;
	end
endmodule // key_learn_and_tag_detect_cmds_tb
